// ==== dv/pwcr_bank_test.sv ====
// Self-checking bench for the modulator control bank over APB
module pwcr_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	// Bench-driven inputs, all given a value at time zero
	logic                   pclk        = 1'b0;
	logic                   presetn     = 1'b0;
	logic                   psel        = 1'b0;
	logic                   penable     = 1'b0;
	logic                   pwrite      = 1'b0;
	logic [11:0]            paddr       = 12'h000;
	logic [31:0]            pwdata      = 32'h0000_0000;
	pwcr_pkg::pwcr_events_t evt_in      = '0;
	logic [63:0]            fetch_words = 64'h2abc_9876_1357_0f1e;
	// Design outputs
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	pwcr_pkg::pwcr_tasks_t  task_out;
	logic                   module_on;
	logic                   centre_aligned_counting;
	logic [14:0]            period_top_value;
	logic [2:0]             prescale_sel;
	logic [63:0]            chan_cmp;
	logic                   irq;
	// Bookkeeping
	int                     err_count   = 0;
	int                     comparisons = 0;
	int                     n_halt      = 0;
	int                     n_a         = 0;
	int                     n_b         = 0;
	int                     bh, ba, bb;
	logic [31:0]            rdat;
	logic                   rerr;

	pwcr_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .evt_in(evt_in), .fetch_words(fetch_words), .task_out(task_out),
		.module_on(module_on), .centre_aligned_counting(centre_aligned_counting),
		.period_top_value(period_top_value), .prescale_sel(prescale_sel),
		.chan_cmp(chan_cmp), .irq(irq));

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	// Count task pulses; a stretched pulse would be counted twice
	always @(posedge pclk) begin
		if (task_out.halt === 1'b1) n_halt <= n_halt + 1;
		if (task_out.seq_a_launch === 1'b1) n_a <= n_a + 1;
		if (task_out.seq_b_launch === 1'b1) n_b <= n_b + 1;
	end

	// Single comparison, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; entered just after an edge, leaves one idle cycle behind
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Zero wait is expected, but the master never assumes it
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask

	// One-cycle event pulse, then let the responses settle
	task automatic pulse(input logic [6:0] v);
		evt_in <= pwcr_pkg::pwcr_events_t'(v);
		@(posedge pclk);
		evt_in <= '0;
		repeat (3) @(posedge pclk);
	endtask

	// Task pulse counts since the last snapshot
	task automatic tcheck(input int eh, input int ea, input int eb);
		// A pulse launched at the last edge is counted only at the next one
		@(posedge pclk);
		chk(32'(n_halt - bh), 32'(eh));
		chk(32'(n_a - ba), 32'(ea));
		chk(32'(n_b - bb), 32'(eb));
		bh = n_halt;
		ba = n_a;
		bb = n_b;
	endtask

	task automatic t_reset;
		rchk(12'h200, 32'h0);
		rchk(12'h300, 32'h0);
		rchk(12'h304, 32'h0);
		rchk(12'h308, 32'h0);
		rchk(12'h500, 32'h0);
		rchk(12'h504, 32'h0);
		rchk(12'h508, 32'h0000_03ff);
		$display("test reset done");
	endtask

	task automatic t_interrupt_enable;
		apb(1'b1, 12'h304, 32'h0000_000a);
		rchk(12'h300, 32'h0000_000a);
		rchk(12'h308, 32'h0000_000a);
		apb(1'b1, 12'h308, 32'h0000_0002);
		rchk(12'h304, 32'h0000_0008);
		// Zero writes to the aliases must not disturb the shared state
		apb(1'b1, 12'h304, 32'h0);
		apb(1'b1, 12'h308, 32'h0);
		rchk(12'h300, 32'h0000_0008);
		apb(1'b1, 12'h300, 32'hffff_ffff);
		rchk(12'h304, 32'h0000_00fe);
		apb(1'b1, 12'h300, 32'h0);
		$display("test interrupt_enable done");
	endtask

	task automatic t_ctrl;
		apb(1'b1, 12'h500, 32'h1);
		chk(32'(module_on), 32'h1);
		apb(1'b1, 12'h500, 32'h0);
		chk(32'(module_on), 32'h0);
		apb(1'b1, 12'h504, 32'h1);
		chk(32'(centre_aligned_counting), 32'h1);
		apb(1'b1, 12'h504, 32'h0);
		chk(32'(centre_aligned_counting), 32'h0);
		apb(1'b1, 12'h508, 32'h0000_7fff);
		chk(32'(period_top_value), 32'h0000_7fff);
		apb(1'b1, 12'h508, 32'h2);
		chk(32'(period_top_value), 32'h3);
		apb(1'b1, 12'h50c, 32'h5);
		chk(32'(prescale_sel), 32'h5);
		apb(1'b0, 12'h7f0, 32'h0);
		chk({rdat[30:0], rerr}, 32'h1);
		// A write to a hole is refused and leaves the bank untouched
		apb(1'b1, 12'h7f0, 32'hffff_ffff);
		chk(32'(rerr), 32'h1);
		chk(32'(period_top_value), 32'h3);
		chk(32'(pready), 32'h1);
		$display("test control done");
	endtask

	// Every load encoding; channel k gets the halfword the encoding names
	task automatic t_decoder;
		int e, k, h;
		for (e = 0; e < 4; e++) begin
			apb(1'b1, 12'h510, 32'(e));
			for (k = 0; k < 4; k++) begin
				h = (e == 0) ? 0 : (e == 1) ? k / 2 : k;
				if (!(e == 3 && k == 3)) chk(32'(chan_cmp[16*k+:16]), 32'(fetch_words[16*h+:16]));
			end
			if (e == 3) chk(32'(period_top_value), 32'(fetch_words[62:48]));
		end
		apb(1'b1, 12'h510, 32'h0);
		chk(32'(period_top_value), 32'h3);
		$display("test decoder done");
	endtask

	task automatic t_shortcut_control;
		bh = n_halt;
		ba = n_a;
		bb = n_b;
		pulse(7'h58);
		tcheck(0, 0, 0);
		apb(1'b1, 12'h200, 32'h0000_001f);
		rchk(12'h200, 32'h0000_001f);
		pulse(7'h08);
		tcheck(1, 0, 0);
		pulse(7'h10);
		tcheck(1, 0, 0);
		pulse(7'h40);
		tcheck(1, 1, 1);
		apb(1'b1, 12'h004, 32'h1);
		tcheck(1, 0, 0);
		apb(1'b1, 12'h008, 32'h1);
		apb(1'b1, 12'h00c, 32'h1);
		tcheck(0, 1, 1);
		apb(1'b1, 12'h200, 32'h0);
		$display("test shortcuts done");
	endtask

	task automatic t_irq;
		rchk(12'h100, 32'h0000_00b0);
		apb(1'b1, 12'h304, 32'h0000_0002);
		pulse(7'h01);
		chk(32'(irq), 32'h1);
		pulse(7'h20);
		rchk(12'h100, 32'h0000_0042);
		chk(32'(irq), 32'h0);
		pulse(7'h20);
		chk(32'(irq), 32'h0);
		apb(1'b1, 12'h304, 32'h0000_0040);
		chk(32'(irq), 32'h1);
		apb(1'b1, 12'h308, 32'h0000_0040);
		chk(32'(irq), 32'h0);
		rchk(12'h100, 32'h0000_0040);
		$display("test interrupt done");
	endtask

	// Verdict and end of run
	task automatic conclude;
		$display("comparisons=%0d mismatches=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog, far beyond the roughly 180 cycles the tests need
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_interrupt_enable();
		t_ctrl();
		t_decoder();
		t_shortcut_control();
		t_irq();
		conclude();
	end
endmodule

// ==== rtl/pwcr_bank.sv ====
// APB control bank of a four-channel sequence-driven modulator
`include "pwcr_defs.svh"
module pwcr_bank (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Events from the sequence player, one-cycle pulses
	input  wire pwcr_pkg::pwcr_events_t evt_in,
	// Fetched halfwords from the memory engine
	input  wire logic [63:0]           fetch_words,
	// Tasks and configuration toward the player
	output pwcr_pkg::pwcr_tasks_t      task_out,
	output logic                       module_on,
	output logic                       centre_aligned_counting,
	output logic [14:0]                period_top_value,
	output logic [2:0]                 prescale_sel,
	output logic [63:0]                chan_cmp,
	// Interrupt
	output logic                       irq
);
	// Bank state
	logic [`PWCR_SHORT_W-1:0]    shortcut_ff;   // Shortcut enables
	logic [`PWCR_EVT_W-1:0]      interrupt_enable_ff;      // Shared enable state
	logic [`PWCR_EVT_W-1:0]      status_ff;     // Sticky event flags
	logic                        enable_ff;     // Module enable
	logic                        mode_ff;       // Counter direction
	logic [`PWCR_TOP_W-1:0]      top_ff;        // Software top value
	logic [`PWCR_PRESCALE_W-1:0] prescale_ff;   // Clock divider select
	logic [`PWCR_DECODER_W-1:0]  decoder_ff;    // Load encoding
	pwcr_pkg::pwcr_tasks_t       task_ff;       // Registered task pulses
	logic [31:0]                 prdata_ff;     // Read data
	logic [14:0]                 mem_top;       // Top from memory
	logic                        mem_top_valid; // Top_from_memory_load load active
	logic [`PWCR_EVT_W-1:0]      evt_vec;       // Events as a vector
	logic                        wr_acc;        // Write access phase
	logic                        rd_acc;        // Read access phase
	logic                        addr_ok;       // Address is mapped
	logic                        rd_status;     // Status read clears flags

	// Match one register offset
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	assign evt_vec = evt_in;

	// Decode of the access phase; zero wait states
	assign wr_acc    = psel & penable & pwrite;
	assign rd_acc    = psel & penable & ~pwrite;
	assign rd_status = rd_acc & hit(paddr, `PWCR_OFF_EVT_STATUS);
	always_comb begin
		addr_ok = hit(paddr, `PWCR_OFF_TASK_HALT) | hit(paddr, `PWCR_OFF_TASK_LAUNCH_A)
			| hit(paddr, `PWCR_OFF_TASK_LAUNCH_B) | hit(paddr, `PWCR_OFF_EVT_STATUS)
			| hit(paddr, `PWCR_OFF_SHORTCUT) | hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE)
			| hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE_SET) | hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE_CLR)
			| hit(paddr, `PWCR_OFF_ENABLE) | hit(paddr, `PWCR_OFF_MODE)
			| hit(paddr, `PWCR_OFF_TOP) | hit(paddr, `PWCR_OFF_PRESCALE)
			| hit(paddr, `PWCR_OFF_DECODER);
	end
	assign pready  = 1'b1;
	// Unmapped addresses answer with an error and have no effect
	assign pslverr = psel & penable & ~addr_ok;

	// Shortcut register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shortcut_ff <= '0;
		end else if (wr_acc && hit(paddr, `PWCR_OFF_SHORTCUT)) begin
			shortcut_ff <= pwdata[`PWCR_SHORT_W-1:0];
		end
	end

	// One enable state behind three views
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable_ff <= '0;
		end else if (wr_acc && hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE)) begin
			interrupt_enable_ff <= pwdata[`PWCR_EVT_W:`PWCR_EVT_LSB];
		end else if (wr_acc && hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE_SET)) begin
			interrupt_enable_ff <= interrupt_enable_ff | pwdata[`PWCR_EVT_W:`PWCR_EVT_LSB];
		end else if (wr_acc && hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE_CLR)) begin
			interrupt_enable_ff <= interrupt_enable_ff & ~pwdata[`PWCR_EVT_W:`PWCR_EVT_LSB];
		end
	end

	// A plain write replaces the whole state; bit 0 is reserved and dropped
	chk_interrupt_enable_load: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `PWCR_OFF_INTERRUPT_ENABLE) |=> interrupt_enable_ff == $past(pwdata[7:1]))
		else $error("enable load wrong");

	// Sticky event flags; a new event beats the read that clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= '0;
		end else begin
			status_ff <= (rd_status ? '0 : status_ff) | evt_vec;
		end
	end

	// An event must never be lost, even when a clearing read lands with it
	chk_status_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(evt_vec != '0) |=> ((status_ff & $past(evt_vec)) == $past(evt_vec)))
		else $error("event flag lost");
	// A quiet read leaves every flag cleared
	chk_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_status && evt_vec == '0) |=> status_ff == '0)
		else $error("status not cleared");

	// Module configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_ff   <= 1'b0;
			mode_ff     <= 1'b0;
			top_ff      <= `PWCR_TOP_RESET;
			prescale_ff <= '0;
			decoder_ff  <= '0;
		end else if (wr_acc) begin
			if (hit(paddr, `PWCR_OFF_ENABLE)) begin
				enable_ff <= pwdata[0];
			end
			if (hit(paddr, `PWCR_OFF_MODE)) begin
				mode_ff <= pwdata[0];
			end
			// Values below the floor are held at the floor
			if (hit(paddr, `PWCR_OFF_TOP)) begin
				top_ff <= (pwdata[14:0] < `PWCR_TOP_MIN) ? `PWCR_TOP_MIN : pwdata[14:0];
			end
			if (hit(paddr, `PWCR_OFF_PRESCALE)) begin
				prescale_ff <= pwdata[`PWCR_PRESCALE_W-1:0];
			end
			if (hit(paddr, `PWCR_OFF_DECODER)) begin
				decoder_ff <= pwdata[`PWCR_DECODER_W-1:0];
			end
		end
	end

	// A legal top value is stored as written
	chk_top_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `PWCR_OFF_TOP && pwdata[14:0] >= `PWCR_TOP_MIN) |=>
		top_ff == $past(pwdata[14:0]))
		else $error("top not stored");
	// Writes to holes in the map must not touch the interrupt enable, shortcut or top register
	chk_unmapped_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && !addr_ok) |=> $stable(interrupt_enable_ff) && $stable(shortcut_ff) && $stable(top_ff))
		else $error("unmapped write took effect");

	// Task pulses: direct writes plus shortcuts from events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			task_ff <= '0;
		end else begin
			task_ff.halt <= (wr_acc & hit(paddr, `PWCR_OFF_TASK_HALT) & pwdata[0])
				| (shortcut_ff[0] & evt_in.seq_a_finished_event)
				| (shortcut_ff[1] & evt_in.seq_b_finished_event)
				| (shortcut_ff[4] & evt_in.all_loops_finished_event);
			task_ff.seq_a_launch <= (wr_acc & hit(paddr, `PWCR_OFF_TASK_LAUNCH_A) & pwdata[0])
				| (shortcut_ff[2] & evt_in.all_loops_finished_event);
			task_ff.seq_b_launch <= (wr_acc & hit(paddr, `PWCR_OFF_TASK_LAUNCH_B) & pwdata[0])
				| (shortcut_ff[3] & evt_in.all_loops_finished_event);
		end
	end

	// Enabled shortcuts 1, 2 and 4 and a direct launch A write fire their task one cycle later
	chk_seq_b_halt: assert property (@(posedge pclk) disable iff (!presetn)
		(shortcut_ff[1] && evt_in.seq_b_finished_event) |=> task_out.halt)
		else $error("shortcut halt b missing");
	chk_loop_a_launch: assert property (@(posedge pclk) disable iff (!presetn)
		(shortcut_ff[2] && evt_in.all_loops_finished_event) |=> task_out.seq_a_launch)
		else $error("shortcut launch a missing");
	chk_loop_halt: assert property (@(posedge pclk) disable iff (!presetn)
		(shortcut_ff[4] && evt_in.all_loops_finished_event) |=> task_out.halt)
		else $error("shortcut loop halt missing");
	chk_launch_a_task: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `PWCR_OFF_TASK_LAUNCH_A && pwdata[0]) |=> task_out.seq_a_launch)
		else $error("launch task missing");

	// Read data mux, registered at the end of the setup cycle for the access cycle of the same read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= '0;
			if (hit(paddr, `PWCR_OFF_SHORTCUT)) begin
				prdata_ff <= {27'h0000000, shortcut_ff};
			end
			// All three views read the same state
			if (hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE) || hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE_SET)
				|| hit(paddr, `PWCR_OFF_INTERRUPT_ENABLE_CLR)) begin
				prdata_ff <= {24'h000000, interrupt_enable_ff, 1'b0};
			end
			if (hit(paddr, `PWCR_OFF_EVT_STATUS)) begin
				prdata_ff <= {24'h000000, status_ff | evt_vec, 1'b0};
			end
			if (hit(paddr, `PWCR_OFF_ENABLE)) begin
				prdata_ff <= {31'h00000000, enable_ff};
			end
			if (hit(paddr, `PWCR_OFF_MODE)) begin
				prdata_ff <= {31'h00000000, mode_ff};
			end
			if (hit(paddr, `PWCR_OFF_TOP)) begin
				prdata_ff <= {17'h00000, top_ff};
			end
			if (hit(paddr, `PWCR_OFF_PRESCALE)) begin
				prdata_ff <= {29'h00000000, prescale_ff};
			end
			if (hit(paddr, `PWCR_OFF_DECODER)) begin
				prdata_ff <= {30'h00000000, decoder_ff};
			end
		end
	end
	assign prdata = prdata_ff;

	// Read data loaded in the setup cycle must stand in the access cycle
	chk_enable_read: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == `PWCR_OFF_ENABLE) |=>
		prdata == {31'h00000000, $past(enable_ff)})
		else $error("enable read wrong");
	chk_clr_view_read: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == `PWCR_OFF_INTERRUPT_ENABLE_CLR) |=>
		prdata == {24'h000000, $past(interrupt_enable_ff), 1'b0})
		else $error("clear view read wrong");

	// Decoder spreading
	pwcr_spread u_spread (
		.load_sel      (decoder_ff),
		.halfwords     (fetch_words),
		.chan_cmp      (chan_cmp),
		.mem_top       (mem_top),
		.mem_top_valid (mem_top_valid)
	);

	// Outputs toward the player
	assign task_out                = task_ff;
	assign module_on               = enable_ff;
	assign centre_aligned_counting = mode_ff;
	// Memory top replaces the register in top_from_memory_load load
	assign period_top_value = mem_top_valid ? mem_top : top_ff;
	assign prescale_sel     = prescale_ff;
	assign irq              = |(status_ff & interrupt_enable_ff);

	// Checks on the shared enable state
	// Set alias ORs its ones in; a zero write therefore changes nothing
	sequence s_set_write;
		psel && penable && pwrite && paddr == `PWCR_OFF_INTERRUPT_ENABLE_SET;
	endsequence
	chk_set_alias_or: assert property (@(posedge pclk) disable iff (!presetn)
		s_set_write |=> (interrupt_enable_ff == ($past(interrupt_enable_ff) | $past(pwdata[7:1]))))
		else $error("set alias wrong");
	// Clear alias removes its ones; a zero write therefore changes nothing
	chk_clr_alias_and: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `PWCR_OFF_INTERRUPT_ENABLE_CLR) |=>
		(interrupt_enable_ff == ($past(interrupt_enable_ff) & ~$past(pwdata[7:1]))))
		else $error("clear alias wrong");
	// Nothing outside the three views may move the state
	chk_interrupt_enable_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_acc && (paddr[11:8] == 4'h3)) |=> $stable(interrupt_enable_ff))
		else $error("enable state moved");

	// Checks on shortcuts and tasks
	chk_short_halt: assert property (@(posedge pclk) disable iff (!presetn)
		(shortcut_ff[0] && evt_in.seq_a_finished_event) |=> task_out.halt)
		else $error("shortcut halt missing");
	chk_loop_launch: assert property (@(posedge pclk) disable iff (!presetn)
		(shortcut_ff[3] && evt_in.all_loops_finished_event) |=> task_out.seq_b_launch)
		else $error("shortcut launch missing");
	// Direct write of the halt task
	chk_halt_task: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `PWCR_OFF_TASK_HALT && pwdata[0]) |=> task_out.halt)
		else $error("halt task missing");

	// Checks on the counter configuration
	// The clamp keeps the register top, not the top from memory, away from degenerate periods
	chk_top_floor: assert property (@(posedge pclk) disable iff (!presetn)
		top_ff >= `PWCR_TOP_MIN)
		else $error("top below floor");
	// Outside top_from_memory_load load the register alone sets the period
	chk_top_source: assert property (@(posedge pclk) disable iff (!presetn)
		(decoder_ff != `PWCR_LOAD_TOP_FROM_MEMORY_LOAD) |-> period_top_value == top_ff)
		else $error("top source wrong");
	chk_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `PWCR_OFF_ENABLE) |=> module_on == $past(pwdata[0]))
		else $error("enable not taken");
	chk_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `PWCR_OFF_MODE) |=> centre_aligned_counting == $past(pwdata[0]))
		else $error("mode not taken");
endmodule

// ==== rtl/pwcr_defs.svh ====
// Offsets, field positions, reset values and widths of the modulator control bank
`ifndef PWCR_DEFS_SVH
`define PWCR_DEFS_SVH
`define PWCR_OFF_TASK_HALT     12'h004
`define PWCR_OFF_TASK_LAUNCH_A 12'h008
`define PWCR_OFF_TASK_LAUNCH_B 12'h00c
`define PWCR_OFF_EVT_STATUS    12'h100
`define PWCR_OFF_SHORTCUT      12'h200
`define PWCR_OFF_INTERRUPT_ENABLE         12'h300
`define PWCR_OFF_INTERRUPT_ENABLE_SET     12'h304
`define PWCR_OFF_INTERRUPT_ENABLE_CLR     12'h308
`define PWCR_OFF_ENABLE        12'h500
`define PWCR_OFF_MODE          12'h504
`define PWCR_OFF_TOP           12'h508
`define PWCR_OFF_PRESCALE      12'h50c
`define PWCR_OFF_DECODER       12'h510
`define PWCR_SHORT_W           5
`define PWCR_EVT_W             7
`define PWCR_EVT_LSB           1
`define PWCR_TOP_W             15
`define PWCR_TOP_RESET         15'h03ff
`define PWCR_TOP_MIN           15'h0003
`define PWCR_PRESCALE_W        3
`define PWCR_DECODER_W         2
`define PWCR_LOAD_TOP_FROM_MEMORY_LOAD     2'h3
`endif

// ==== rtl/pwcr_pkg.sv ====
// Types shared by the modulator control bank
package pwcr_pkg;
	// Event order matches interrupt bits 1..7
	typedef struct packed {
		logic all_loops_finished_event;
		logic period_finished_event;
		logic seq_b_finished_event;
		logic seq_a_finished_event;
		logic seq_b_launched_event;
		logic seq_a_launched_event;
		logic stopped_event;
	} pwcr_events_t;
	// Task pulses toward the sequence player
	typedef struct packed {
		logic halt;
		logic seq_a_launch;
		logic seq_b_launch;
	} pwcr_tasks_t;
	// Decoder spreading encodings
	typedef enum logic [1:0] {
		PWCR_LOAD_COMMON     = 2'b00,
		PWCR_LOAD_GROUPED    = 2'b01,
		PWCR_LOAD_INDIVIDUAL = 2'b10,
		PWCR_LOAD_TOP_FROM_MEMORY_LOAD   = 2'b11
	} pwcr_load_t;
endpackage

// ==== rtl/pwcr_spread.sv ====
// Spreads fetched halfwords over four channels per decoder load setting
module pwcr_spread (
	// Setting and fetched data
	input  wire logic [1:0]  load_sel,
	input  wire logic [63:0] halfwords,
	// Channel compare values and top from memory
	output logic      [63:0] chan_cmp,
	output logic      [14:0] mem_top,
	output logic             mem_top_valid
);
	// Word k sits at halfwords[16k+:16]
	always_comb begin
		chan_cmp      = '0;
		mem_top       = halfwords[62:48];
		mem_top_valid = 1'b0;
		unique case (pwcr_pkg::pwcr_load_t'(load_sel))
			// One halfword to every channel
			pwcr_pkg::PWCR_LOAD_COMMON: begin
				chan_cmp = {4{halfwords[15:0]}};
			end
			// Channels 0,1 from word 0; 2,3 from word 1
			pwcr_pkg::PWCR_LOAD_GROUPED: begin
				chan_cmp = {{2{halfwords[31:16]}}, {2{halfwords[15:0]}}};
			end
			// One word per channel
			pwcr_pkg::PWCR_LOAD_INDIVIDUAL: begin
				chan_cmp = halfwords;
			end
			// Three channels, fourth word is the counter top
			pwcr_pkg::PWCR_LOAD_TOP_FROM_MEMORY_LOAD: begin
				chan_cmp      = {16'h0000, halfwords[47:0]};
				mem_top_valid = 1'b1;
			end
		endcase
	end
endmodule
